//--- design/adc_control_interface.sv
// Control and result register block of a 12-bit analog-to-digital converter.
//
// Contract
// - Conversion gives a 12-bit unsigned result in a high and low byte.
// - Format 0: result MSB at high bit 7, LSB at low bit 4.
// - Format 1: right-justified, MSB at high bit 3, LSB at low bit 0.
// - Result bits not carrying data read as zero.
// - A start pulse high then low begins a conversion.
// - Start held high keeps converter in reset and busy flag at 1.
// - Busy flag is 1 while converting, 0 when done, resets to 1.
// - Power-off bit 1 powers converter down; resets to 1.
// - Channel field selects external input 0 to 3 when internal ref off.
// - Internal-ref select routes bandgap and disconnects external inputs.
// - Bandgap switches off when unused by converter and low-voltage logic.
// - Reference select: 0 supply, 1 external reference pin; resets to 0.
// - Clock field codes 0 to 6 divide system clock by 1 to 64.
// - Pin analog-enable gives pin to converter, clear restores digital use.
// - Analog pins have their pull-high resistor disconnected.
// - Enable bits 0 to 3 map to pins 0 to 3, reset to 1.
// - Unimplemented control bits read zero and ignore writes.
// - Conversion end sets the converter interrupt request flag.
`timescale 1ns/1ps
module adc_control_interface (
   // APB clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic [31:0]                     prdata,
   output logic                            pslverr,
   // Converter core
   input  wire logic [11:0]                sample_value,
   output logic                            converter_reset,
   output logic                            converter_clk_en,
   output adc_ctrl_pkg::analog_ctrl_s      analog_ctrl,
   // Interrupt controller
   output logic                            conversion_done_irq
);

   // Registers.
   logic [7:0]                 ctrl0_q;
   logic [7:0]                 ctrl1_q;
   logic [7:0]                 pin_q;
   logic [1:0]                 sys_q;
   logic                       busy_q;
   logic                       irq_q;
   logic [11:0]                result_q;
   logic [5:0]                 div_cnt_q;
   logic [4:0]                 tick_cnt_q;
   logic                       start_prev_q;
   adc_ctrl_pkg::conv_state_e  state_q;
   logic                       conv_rst_q;
   logic                       clk_en_q;
   adc_ctrl_pkg::analog_ctrl_s actl_q;
   logic                       pready_q;
   logic [31:0]                prdata_q;
   logic                       pslverr_q;

   // Bus decode.
   logic       acc;
   logic       wr;
   logic       rd;
   logic       hit_c0;
   logic       hit_c1;
   logic       hit_pin;
   logic       hit_irq;
   logic       hit_sys;
   logic       mapped;
   logic [7:0] rd_byte;
   logic [7:0] res_low;
   logic [7:0] res_high;

   assign acc     = psel & penable & ~pready_q;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign hit_c0  = paddr == adc_ctrl_pkg::OFF_CONTROL_0;
   assign hit_c1  = paddr == adc_ctrl_pkg::OFF_CONTROL_1;
   assign hit_pin = paddr == adc_ctrl_pkg::OFF_PIN_ENABLE;
   assign hit_irq = paddr == adc_ctrl_pkg::OFF_IRQ_FLAG;
   assign hit_sys = paddr == adc_ctrl_pkg::OFF_SYSTEM;
   assign mapped  = hit_c0 | hit_c1 | hit_pin | hit_irq | hit_sys
                  | (paddr == adc_ctrl_pkg::OFF_RESULT_LOW)
                  | (paddr == adc_ctrl_pkg::OFF_RESULT_HIGH);

   // Result justification; unused bits are zero.
   assign res_high = ctrl0_q[adc_ctrl_pkg::C0_FORMAT]
                   ? {4'h0, result_q[11:8]}
                   : result_q[11:4];
   assign res_low  = ctrl0_q[adc_ctrl_pkg::C0_FORMAT]
                   ? result_q[7:0]
                   : {result_q[3:0], 4'h0};

   // Read mux; the busy flag is merged into its bit of control 0.
   always_comb begin
      rd_byte = 8'h00;
      unique case (paddr)
         adc_ctrl_pkg::OFF_RESULT_LOW:  rd_byte = res_low;
         adc_ctrl_pkg::OFF_RESULT_HIGH: rd_byte = res_high;
         adc_ctrl_pkg::OFF_CONTROL_0:
            rd_byte = ctrl0_q | {1'b0, busy_q, 6'h00};
         adc_ctrl_pkg::OFF_CONTROL_1:   rd_byte = ctrl1_q;
         adc_ctrl_pkg::OFF_PIN_ENABLE:  rd_byte = pin_q;
         adc_ctrl_pkg::OFF_IRQ_FLAG:    rd_byte = {7'h00, irq_q};
         adc_ctrl_pkg::OFF_SYSTEM:      rd_byte = {6'h00, sys_q};
         default:                       rd_byte = 8'h00;
      endcase
   end

   // APB answer: one wait state, error on unmapped address.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~mapped;
         prdata_q  <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Software-written registers; writes are masked to implemented bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_q <= adc_ctrl_pkg::C0_RESET;
         ctrl1_q <= adc_ctrl_pkg::C1_RESET;
         pin_q   <= adc_ctrl_pkg::PIN_RESET;
         sys_q   <= adc_ctrl_pkg::SYS_RESET;
      end else if (wr) begin
         if (hit_c0) begin
            ctrl0_q <= pwdata[7:0] & adc_ctrl_pkg::C0_WMASK;
         end
         if (hit_c1) begin
            ctrl1_q <= pwdata[7:0] & adc_ctrl_pkg::C1_WMASK;
         end
         if (hit_pin) begin
            pin_q <= pwdata[7:0] & adc_ctrl_pkg::PIN_WMASK;
         end
         if (hit_sys) begin
            sys_q <= pwdata[1:0];
         end
      end
   end

   // Converter clock divider: ratio 2 to the power of the code.
   logic [2:0] div_code;
   logic [5:0] div_max;
   logic       adc_tick;
   logic       start_bit;
   logic       start_fall;
   logic       powered;

   assign div_code   = ctrl1_q[2:0];
   assign div_max    = 6'((7'h01 << div_code) - 7'h01);
   assign adc_tick   = (div_code != adc_ctrl_pkg::DIV_STOPPED)
                     & (div_cnt_q >= div_max);
   assign start_bit  = ctrl0_q[adc_ctrl_pkg::C0_START];
   assign start_fall = start_prev_q & ~start_bit;
   assign powered    = ~ctrl0_q[adc_ctrl_pkg::C0_OFF];

   // Divider counter, restarted by a new conversion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 6'h00;
      end else if (adc_tick || start_fall) begin
         div_cnt_q <= 6'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // Conversion sequencer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q      <= adc_ctrl_pkg::ST_IDLE;
         busy_q       <= 1'b1;
         tick_cnt_q   <= 5'h00;
         start_prev_q <= 1'b0;
         result_q     <= 12'h000;
         irq_q        <= 1'b0;
      end else begin
         start_prev_q <= start_bit;
         // Set wins over a same-cycle software clear.
         if (state_q == adc_ctrl_pkg::ST_CONV && adc_tick &&
             tick_cnt_q == adc_ctrl_pkg::CONV_TICKS - 5'h01) begin
            irq_q <= 1'b1;
         end else if (wr && hit_irq && pwdata[0]) begin
            irq_q <= 1'b0;
         end
         unique case (state_q)
            adc_ctrl_pkg::ST_IDLE: begin
               if (start_bit) begin
                  state_q <= adc_ctrl_pkg::ST_RESET;
                  busy_q  <= 1'b1;
               end
            end
            adc_ctrl_pkg::ST_RESET: begin
               busy_q <= 1'b1;
               if (start_fall && powered) begin
                  state_q    <= adc_ctrl_pkg::ST_CONV;
                  tick_cnt_q <= 5'h00;
               end else if (start_fall) begin
                  state_q <= adc_ctrl_pkg::ST_IDLE;
               end
            end
            adc_ctrl_pkg::ST_CONV: begin
               if (start_bit) begin
                  state_q <= adc_ctrl_pkg::ST_RESET;
               end else if (adc_tick) begin
                  if (tick_cnt_q == adc_ctrl_pkg::CONV_TICKS - 5'h01) begin
                     result_q <= sample_value;
                     busy_q   <= 1'b0;
                     state_q  <= adc_ctrl_pkg::ST_IDLE;
                  end else begin
                     tick_cnt_q <= tick_cnt_q + 5'h01;
                  end
               end
            end
            default: begin
               state_q <= adc_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Analog routing and core control outputs, all registered.
   adc_ctrl_pkg::analog_ctrl_s actl_d;
   logic                       bg_use;

   assign bg_use = ctrl1_q[adc_ctrl_pkg::C1_BGEN];

   always_comb begin
      actl_d               = '0;
      actl_d.power_on      = powered;
      actl_d.bandgap_on    = bg_use | sys_q[0] | sys_q[1];
      actl_d.internal_ref  = ctrl1_q[adc_ctrl_pkg::C1_INTREF];
      actl_d.channel       = ctrl1_q[adc_ctrl_pkg::C1_INTREF]
                           ? 2'h0 : ctrl0_q[1:0];
      actl_d.external_vref = ctrl1_q[adc_ctrl_pkg::C1_REFSEL];
      actl_d.pin_analog    = ctrl1_q[adc_ctrl_pkg::C1_INTREF]
                           ? 4'h0 : pin_q[3:0];
      actl_d.pull_high_off = pin_q[3:0];
   end

   // Output flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         actl_q     <= '0;
         conv_rst_q <= 1'b1;
         clk_en_q   <= 1'b0;
      end else begin
         actl_q     <= actl_d;
         conv_rst_q <= (state_q != adc_ctrl_pkg::ST_CONV) | ~powered;
         clk_en_q   <= adc_tick & powered;
      end
   end

   assign pready              = pready_q;
   assign prdata              = prdata_q;
   assign pslverr             = pslverr_q;
   assign converter_reset     = conv_rst_q;
   assign converter_clk_en    = clk_en_q;
   assign analog_ctrl         = actl_q;
   assign conversion_done_irq = irq_q;

endmodule : adc_control_interface

//--- design/adc_ctrl_pkg.sv
// Package with register map, field positions, reset values and timing.
package adc_ctrl_pkg;

   // Register byte offsets on the 32-bit bus.
   localparam logic [11:0] OFF_RESULT_LOW  = 12'h000;
   localparam logic [11:0] OFF_RESULT_HIGH = 12'h004;
   localparam logic [11:0] OFF_CONTROL_0   = 12'h008;
   localparam logic [11:0] OFF_CONTROL_1   = 12'h00c;
   localparam logic [11:0] OFF_PIN_ENABLE  = 12'h010;
   localparam logic [11:0] OFF_IRQ_FLAG    = 12'h014;
   localparam logic [11:0] OFF_SYSTEM      = 12'h018;

   // Field positions in converter_control_0.
   localparam int C0_START  = 7;
   localparam int C0_BUSY   = 6;
   localparam int C0_OFF    = 5;
   localparam int C0_FORMAT = 4;

   // Field positions in converter_control_1.
   localparam int C1_INTREF = 7;
   localparam int C1_BGEN   = 6;
   localparam int C1_REFSEL = 4;

   // Writable bit masks of the control registers.
   localparam logic [7:0] C0_WMASK  = 8'hb3;
   localparam logic [7:0] C1_WMASK  = 8'hd7;
   localparam logic [7:0] PIN_WMASK = 8'h0f;

   // Reset values.
   localparam logic [7:0] C0_RESET  = 8'h20;
   localparam logic [7:0] C1_RESET  = 8'h00;
   localparam logic [7:0] PIN_RESET = 8'h0f;
   localparam logic [1:0] SYS_RESET = 2'h0;

   // Reserved divider code that stops the converter clock.
   localparam logic [2:0] DIV_STOPPED = 3'h7;

   // Conversion length in converter clock periods.
   localparam logic [4:0] CONV_TICKS = 5'h10;

   // Converter states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RESET = 3'b010,
      ST_CONV  = 3'b100
   } conv_state_e;

   // Analog routing outputs travelling together.
   typedef struct packed {
      logic       power_on;
      logic       bandgap_on;
      logic       internal_ref;
      logic [1:0] channel;
      logic       external_vref;
      logic [3:0] pin_analog;
      logic [3:0] pull_high_off;
   } analog_ctrl_s;

endpackage : adc_ctrl_pkg

//--- testbench/adc_core_model.sv
// Behavioural model of the analog core that supplies conversion results.
`timescale 1ns/1ps
module adc_core_model (
   // Core control from the block
   input  wire logic        converter_reset,
   // Value that the bench wants converted
   input  wire logic [11:0] core_value,
   // Result towards the block
   output logic [11:0]      sample_value
);
   // Outside a conversion the output is inverted so a stale capture shows.
   assign sample_value = converter_reset ? ~core_value : core_value;
endmodule : adc_core_model

//--- testbench/adc_ctrl_asserts.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
module adc_ctrl_asserts (
   // Clock and reset
   input logic                       pclk,
   input logic                       presetn,
   // Register bus
   input logic                       psel,
   input logic                       penable,
   input logic                       pwrite,
   input logic [11:0]                paddr,
   input logic [31:0]                pwdata,
   input logic                       pready,
   input logic [31:0]                prdata,
   input logic                       pslverr,
   // Converter side
   input logic [11:0]                sample_value,
   input logic                       converter_reset,
   input logic                       converter_clk_en,
   input adc_ctrl_pkg::analog_ctrl_s analog_ctrl,
   input logic                       conversion_done_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer timing and the width of the answer.
   answer_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
   answer_pulse_a: assert property (pready |=> !pready) else $error("answer too long");
   error_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
   // Start held high and power-off both keep the core in reset.
   start_reset_a: assert property (psel && penable && !pready && pwrite && paddr == adc_ctrl_pkg::OFF_CONTROL_0 && pwdata[7] |-> ##[1:3] converter_reset) else $error("start not resetting");
   power_off_a: assert property (!analog_ctrl.power_on [*3] |-> converter_reset && !converter_clk_en) else $error("core runs unpowered");
   // Routing of pins, pull-ups, the internal reference and the reference select.
   pull_off_a: assert property (!analog_ctrl.internal_ref |-> analog_ctrl.pin_analog == analog_ctrl.pull_high_off) else $error("pull-up left on");
   intref_only_a: assert property (analog_ctrl.internal_ref |-> analog_ctrl.channel == 2'h0 && analog_ctrl.pin_analog == 4'h0) else $error("inputs not cut");
   vref_set_a: assert property (psel && penable && !pready && pwrite && paddr == adc_ctrl_pkg::OFF_CONTROL_1 && pwdata[4] |-> ##[1:3] analog_ctrl.external_vref) else $error("vref not chosen");
endmodule : adc_ctrl_asserts

//--- testbench/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb_top;
   logic                       pclk = 1'b0;
   logic                       presetn = 1'b0;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic [11:0]                paddr = 12'h000;
   logic [31:0]                pwdata = 32'h0;
   logic [11:0]                core_value = 12'h000;
   logic                       pready, pslverr, converter_reset;
   logic                       converter_clk_en, conversion_done_irq;
   logic [31:0]                prdata, rd, seed;
   logic [11:0]                sample_value;
   logic [15:0]                res;
   logic [7:0]                 f;
   logic                       err;
   adc_ctrl_pkg::analog_ctrl_s analog_ctrl;
   int                         miscompares = 0;
   int                         checks = 0;
   // Clock at 125 MHz.
   always #4 pclk = ~pclk;
   adc_control_interface i_adc_control_interface (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sample_value(sample_value),
      .converter_reset(converter_reset), .converter_clk_en(converter_clk_en),
      .analog_ctrl(analog_ctrl), .conversion_done_irq(conversion_done_irq));
   adc_core_model i_adc_core_model (.converter_reset(converter_reset),
      .core_value(core_value), .sample_value(sample_value));
   // Next value of the repeatable random sequence.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Result bytes, high then low, for a format and a 12-bit value.
   function automatic logic [15:0] bytes_of(input logic fm, input logic [11:0] r);
      return fm ? {4'h0, r} : {r, 4'h0};
   endfunction : bytes_of
   // Prints the verdict and ends the run.
   task automatic tally_and_finish();
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // Compares one value and reports a mismatch.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // One bus transfer: setup, access until ready, then release.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      // A slave that never answers counts as a mismatch.
      if (n >= 20) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Reads a register and compares it.
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask : rchk
   // Hang guard.
   initial begin
      #(8 * 60000);
      miscompares++;
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      seed = 32'h08a27706;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(adc_ctrl_pkg::OFF_CONTROL_0, 32'h60);
      rchk(adc_ctrl_pkg::OFF_CONTROL_1, 32'h00);
      rchk(adc_ctrl_pkg::OFF_PIN_ENABLE, 32'h0f);
      rchk(adc_ctrl_pkg::OFF_RESULT_HIGH, 32'h00);
      rchk(12'h040, 32'h0);
      cmp({31'h0, err}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, {24'h0, seed[7:0] & 8'h7f});
         rchk(adc_ctrl_pkg::OFF_CONTROL_1, {24'h0, seed[7:0] & 8'h57});
         apb(1'b1, adc_ctrl_pkg::OFF_PIN_ENABLE, seed);
         rchk(adc_ctrl_pkg::OFF_PIN_ENABLE, {28'h0, seed[3:0]});
         cmp(analog_ctrl.pin_analog, seed[3:0]);
      end
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, 32'h10);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, 32'h40);
      repeat (20) @(posedge pclk);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, 32'hc0);
      cmp({analog_ctrl.internal_ref, analog_ctrl.bandgap_on}, 32'h3);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, 32'h00);
      repeat (10) @(posedge pclk);
      for (int c = 0; c < 7; c++) begin
         seed = xs(seed);
         core_value <= seed[11:0];
         f = {3'h0, c[0], 2'h0, c[1:0]};
         apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, c);
         apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, {24'h0, f | 8'h80});
         rchk(adc_ctrl_pkg::OFF_CONTROL_0, {24'h0, f | 8'hc0});
         cmp(analog_ctrl.channel, c[1:0]);
         cmp(analog_ctrl.bandgap_on, 32'h0);
         apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, {24'h0, f});
         rchk(adc_ctrl_pkg::OFF_CONTROL_0, {24'h0, f | 8'h40});
         for (int n = 0; n < 400 && rd[6] !== 1'b0; n++)
            apb(1'b0, adc_ctrl_pkg::OFF_CONTROL_0, 32'h0);
         cmp(rd, {24'h0, f});
         res = bytes_of(c[0], seed[11:0]);
         core_value <= ~seed[11:0];
         rchk(adc_ctrl_pkg::OFF_RESULT_HIGH, {24'h0, res[15:8]});
         rchk(adc_ctrl_pkg::OFF_RESULT_LOW, {24'h0, res[7:0]});
         rchk(adc_ctrl_pkg::OFF_IRQ_FLAG, 32'h1);
         cmp(conversion_done_irq, 32'h1);
         apb(1'b1, adc_ctrl_pkg::OFF_IRQ_FLAG, 32'h1);
         rchk(adc_ctrl_pkg::OFF_IRQ_FLAG, 32'h0);
         cmp(conversion_done_irq, 32'h0);
      end
      // Low-voltage logic alone keeps the bandgap running.
      apb(1'b1, adc_ctrl_pkg::OFF_SYSTEM, 32'h1);
      rchk(adc_ctrl_pkg::OFF_SYSTEM, 32'h1);
      cmp(analog_ctrl.bandgap_on, 32'h1);
      apb(1'b1, adc_ctrl_pkg::OFF_SYSTEM, 32'h0);
      cmp(analog_ctrl.bandgap_on, 32'h0);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_1, 32'h07);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, 32'h80);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, 32'h00);
      repeat (200) @(posedge pclk);
      rchk(adc_ctrl_pkg::OFF_CONTROL_0, 32'h40);
      apb(1'b1, adc_ctrl_pkg::OFF_CONTROL_0, 32'h20);
      rchk(adc_ctrl_pkg::OFF_CONTROL_0, 32'h60);
      tally_and_finish();
   end
endmodule : tb_top
// Checker attached beside the block.
bind adc_control_interface adc_ctrl_asserts i_adc_ctrl_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .sample_value(sample_value),
   .converter_reset(converter_reset), .converter_clk_en(converter_clk_en),
   .analog_ctrl(analog_ctrl), .conversion_done_irq(conversion_done_irq));
